// ==== core/dsrs_consts.vh ====
/*
 Named constants of the disk read sector sequencer: register map,
 control field positions, function codes, sector geometry, CRC and
 timeout figures. Definitions only; included by the CRC and sequencer files and the bench top.
*/
`ifndef DSRS_CONSTS_VH
`define DSRS_CONSTS_VH

// Register byte offsets on the APB side
`define DSRS_OFS_CTL      12'h000
`define DSRS_OFS_BUSADDR  12'h004
`define DSRS_OFS_DISKADDR 12'h008
`define DSRS_OFS_WORDCNT  12'h00c

// Control register field positions
`define DSRS_F_DRDY    0
`define DSRS_F_FN_LO   1
`define DSRS_F_FN_HI   3
`define DSRS_F_IEN     6
`define DSRS_F_RDY     7
`define DSRS_F_DS_LO   8
`define DSRS_F_DS_HI   9
`define DSRS_F_EHCRC   10
`define DSRS_F_EDCRC   11
`define DSRS_F_ELATE   12
`define DSRS_F_ETMO    13
`define DSRS_F_ERR     15

// Reset values
`define DSRS_RST_WORD  16'h0000
`define DSRS_RST_FN    3'h0
`define DSRS_RST_DS    2'h0
`define DSRS_RST_BUS   32'h0000_0000

// Function codes served by this sequencer
`define DSRS_FN_READ   3'h6
`define DSRS_FN_RAW    3'h7

// Sector geometry, in bits counted from zero
`define DSRS_CNT_W     12
`define DSRS_CNT_ZERO  12'h000
`define DSRS_CNT_ONE   12'h001
`define DSRS_HDR_LAST  12'h02f
`define DSRS_DATA_LAST 12'h7ff
`define DSRS_SECT_LAST 12'h80f
`define DSRS_WORD_END  4'hf

// Serial CRC
`define DSRS_CRC_POLY  16'h8005
`define DSRS_CRC_INIT  16'h0000

// Counters and steps
`define DSRS_WORD_ONE  16'h0001
`define DSRS_BAR_STEP  16'h0002

// Operation incomplete timeout: 490 ms at 50 MHz
`define DSRS_TMO_MS    490
`define DSRS_CLK_KHZ   50000
`define DSRS_TMO_W     25
`define DSRS_TMO_ZERO  25'h0000000
`define DSRS_TMO_ONE   25'h0000001
`define DSRS_TMO_CYC   25'h175d720

`endif

// ==== core/dsrs_crc16.v ====
/*
 Serial CRC-16 register, one bit per enable, MSB first.
 Assumes the caller clears it before each field; a field that carries
 its own check word leaves zero in the register when it is good.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dsrs_consts.vh"

module dsrs_crc16 #(
   parameter [15:0] POLY = `DSRS_CRC_POLY
) (
   // Clock, reset and enable
   input  wire        pclk,
   input  wire        presetn,
   input  wire        ce,
   // Control and serial data
   input  wire        clr,
   input  wire        en,
   input  wire        bit_in,
   // Running remainder
   output reg  [15:0] crc_q
);

   wire        fb_d;
   wire [15:0] crc_d;

   // Shift with feedback
   assign fb_d  = bit_in ^ crc_q[15];
   assign crc_d = {crc_q[14:0], 1'b0} ^ (fb_d ? POLY : 16'h0000);

   // Remainder register
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         crc_q <= `DSRS_CRC_INIT;
      end else if (ce) begin
         if (clr) begin
            crc_q <= `DSRS_CRC_INIT;
         end else if (en) begin
            crc_q <= crc_d;
         end
      end
   end

endmodule
`default_nettype wire

// ==== core/dsrs_hdr_cmp.v ====
/*
 Serial header comparator: one incoming bit against one bit of the
 serialised disk address, latching any difference.
 Assumes the caller clears it at the start of every header.
*/
`timescale 1ns/1ps
`default_nettype none

module dsrs_hdr_cmp (
   // Clock, reset and enable
   input  wire pclk,
   input  wire presetn,
   input  wire ce,
   // Control and bits to compare
   input  wire clr,
   input  wire en,
   input  wire bit_in,
   input  wire ref_bit,
   // Sticky mismatch
   output reg  miss_q
);

   // Mismatch latch
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         miss_q <= 1'b0;
      end else if (ce) begin
         if (clr) begin
            miss_q <= 1'b0;
         end else if (en && (bit_in != ref_bit)) begin
            miss_q <= 1'b1;
         end
      end
   end

endmodule
`default_nettype wire

// ==== core/dsrs_read_seq.v ====
/*
 Disk read sector sequencer: APB register slave, command sequencer for
 the read data and read without header check functions, serial header
 compare, CRC checks, FIFO write side, DMA enable and word counting.
 Assumes an external FIFO that reports half empty, an external DMA
 engine that pulses once per word moved to memory, and drive inputs
 synchronous to pclk with one strobe per serial bit.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dsrs_consts.vh"

module dsrs_read_seq #(
   parameter [`DSRS_TMO_W-1:0] TMO_CYCLES = `DSRS_TMO_CYC
) (
   // Clock, reset and enable
   input  wire        pclk,
   input  wire        presetn,
   input  wire        ce,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata_q,
   output reg         pready_q,
   output reg         pslverr_q,
   // Drive serial side
   input  wire        drive_ready,
   input  wire        sector_pulse,
   input  wire        rd_bit_stb,
   input  wire        rd_bit,
   output reg  [1:0]  drv_sel_q,
   // FIFO write side
   input  wire        fifo_half_empty,
   output reg         fifo_wr_q,
   output reg  [15:0] fifo_wdata_q,
   // DMA side
   input  wire        dma_word_done,
   output reg         dma_en_q,
   output reg  [15:0] dma_addr_q,
   // Completion request
   output reg         irq_q
);

   // Sequencer states
   localparam [8:0] ST_IDLE  = 9'h001;
   localparam [8:0] ST_DRDY  = 9'h002;
   localparam [8:0] ST_SECT  = 9'h004;
   localparam [8:0] ST_HDR   = 9'h008;
   localparam [8:0] ST_HCHK  = 9'h010;
   localparam [8:0] ST_DATA  = 9'h020;
   localparam [8:0] ST_DCHK  = 9'h040;
   localparam [8:0] ST_DRAIN = 9'h080;
   localparam [8:0] ST_DONE  = 9'h100;

   localparam [`DSRS_TMO_W-1:0] TMO_LAST = TMO_CYCLES - `DSRS_TMO_ONE;

   reg  [8:0]             st_q;
   reg  [`DSRS_CNT_W-1:0] bit_cnt_q;
   reg  [15:0]            data_sr_q;
   reg  [15:0]            push_left_q;
   reg  [2:0]             function_q;
   reg                    interrupt_enable_bit_q;
   reg                    controller_ready_flag_q;
   reg  [15:0]            disk_address_register_q;
   reg  [15:0]            word_counter_q;
   reg                    wc_ovf_q;
   reg                    dma_on_q;
   reg                    err_hcrc_q;
   reg                    err_dcrc_q;
   reg                    err_late_q;
   reg                    err_tmo_q;
   reg  [`DSRS_TMO_W-1:0] tmo_cnt_q;
   reg  [15:0]            ctl_rd_d;
   reg  [31:0]            rd_word_d;
   reg                    mapped_d;
   wire                   idle_w;
   wire                   err_any_w;
   wire                   wr_acc_w;
   wire                   start_w;
   wire                   dar_inc_w;
   wire                   tmo_hit_w;
   wire                   raw_w;
   wire                   word_step_w;
   wire                   crc_clr_w;
   wire                   crc_en_w;
   wire                   cmp_clr_w;
   wire                   cmp_en_w;
   wire                   ref_bit_w;
   wire                   hdr_miss_w;
   wire [15:0]            crc_w;

   // Common terms
   assign idle_w    = (st_q == ST_IDLE);
   assign err_any_w = err_hcrc_q | err_dcrc_q | err_late_q | err_tmo_q;
   assign wr_acc_w  = psel & penable & pwrite & pready_q;
   assign raw_w     = (function_q == `DSRS_FN_RAW);
   assign tmo_hit_w = !idle_w && (st_q != ST_DONE) && (tmo_cnt_q == TMO_LAST);
   assign start_w   = wr_acc_w && idle_w && (paddr == `DSRS_OFS_CTL) &&
                      !pwdata[`DSRS_F_RDY];
   assign dar_inc_w = (st_q == ST_DCHK) && !tmo_hit_w && !raw_w &&
                      (crc_w == `DSRS_CRC_INIT);
   assign word_step_w = dma_word_done && dma_en_q && !wc_ovf_q;

   // CRC over header and data fields, each with its check word
   assign crc_clr_w = (st_q == ST_SECT) || (st_q == ST_HCHK);
   assign crc_en_w  = rd_bit_stb && ((st_q == ST_HDR) || (st_q == ST_DATA));
   // serial address compare on first header word
   assign cmp_clr_w = (st_q == ST_SECT);
   assign cmp_en_w  = rd_bit_stb && (st_q == ST_HDR) &&
                      (bit_cnt_q[`DSRS_CNT_W-1:4] == 8'h00);
   assign ref_bit_w = disk_address_register_q[~bit_cnt_q[3:0]];

   // CRC checker shared by header and data fields
   dsrs_crc16 #(
      .POLY    (`DSRS_CRC_POLY)
   ) u_crc (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .clr     (crc_clr_w),
      .en      (crc_en_w),
      .bit_in  (rd_bit),
      .crc_q   (crc_w)
   );

   // Header address comparator
   dsrs_hdr_cmp u_cmp (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .clr     (cmp_clr_w),
      .en      (cmp_en_w),
      .bit_in  (rd_bit),
      .ref_bit (ref_bit_w),
      .miss_q  (hdr_miss_w)
   );

   // Control register read image
   always @* begin
      ctl_rd_d = `DSRS_RST_WORD;
      ctl_rd_d[`DSRS_F_DRDY] = drive_ready;
      ctl_rd_d[`DSRS_F_FN_HI:`DSRS_F_FN_LO] = function_q;
      ctl_rd_d[`DSRS_F_IEN] = interrupt_enable_bit_q;
      ctl_rd_d[`DSRS_F_RDY] = controller_ready_flag_q;
      ctl_rd_d[`DSRS_F_DS_HI:`DSRS_F_DS_LO] = drv_sel_q;
      ctl_rd_d[`DSRS_F_EHCRC] = err_hcrc_q;
      ctl_rd_d[`DSRS_F_EDCRC] = err_dcrc_q;
      ctl_rd_d[`DSRS_F_ELATE] = err_late_q;
      ctl_rd_d[`DSRS_F_ETMO] = err_tmo_q;
      ctl_rd_d[`DSRS_F_ERR] = err_any_w;
   end

   // Read data and address decode
   always @* begin
      rd_word_d = `DSRS_RST_BUS;
      mapped_d  = 1'b1;
      case (paddr)
         `DSRS_OFS_CTL: begin
            rd_word_d[15:0] = ctl_rd_d;
         end
         `DSRS_OFS_BUSADDR: begin
            rd_word_d[15:0] = dma_addr_q;
         end
         `DSRS_OFS_DISKADDR: begin
            rd_word_d[15:0] = disk_address_register_q;
         end
         `DSRS_OFS_WORDCNT: begin
            rd_word_d[15:0] = word_counter_q;
         end
         default: begin
            mapped_d = 1'b0;
         end
      endcase
   end

   // APB answer: captured in setup, presented in the access cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q  <= `DSRS_RST_BUS;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end else if (ce) begin
         pready_q  <= psel && !penable;
         pslverr_q <= psel && !penable && !mapped_d;
         if (psel && !penable && !pwrite) begin
            prdata_q <= rd_word_d;
         end
      end
   end

   // Command fields; writes while busy are refused
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         function_q             <= `DSRS_RST_FN;
         interrupt_enable_bit_q <= 1'b0;
         drv_sel_q              <= `DSRS_RST_DS;
      end else if (ce) begin
         if (wr_acc_w && idle_w && (paddr == `DSRS_OFS_CTL)) begin
            function_q <= pwdata[`DSRS_F_FN_HI:`DSRS_F_FN_LO];
            interrupt_enable_bit_q <= pwdata[`DSRS_F_IEN];
            drv_sel_q <= pwdata[`DSRS_F_DS_HI:`DSRS_F_DS_LO];
         end
      end
   end

   // Disk address register: loaded when idle, bumped per good sector except in raw read
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         disk_address_register_q <= `DSRS_RST_WORD;
      end else if (ce) begin
         if (wr_acc_w && idle_w && (paddr == `DSRS_OFS_DISKADDR)) begin
            disk_address_register_q <= pwdata[15:0];
         end else if (dar_inc_w) begin
            disk_address_register_q <= disk_address_register_q +
                                       `DSRS_WORD_ONE;
         end
      end
   end

   // Word counter and memory address, stepped per word to memory
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         word_counter_q <= `DSRS_RST_WORD;
         wc_ovf_q       <= 1'b1;
         dma_addr_q     <= `DSRS_RST_WORD;
      end else if (ce) begin
         if (wr_acc_w && idle_w && (paddr == `DSRS_OFS_WORDCNT)) begin
            word_counter_q <= pwdata[15:0];
            wc_ovf_q       <= (pwdata[15:0] == `DSRS_RST_WORD);
         end else if (word_step_w) begin
            word_counter_q <= word_counter_q - `DSRS_WORD_ONE;
            wc_ovf_q       <= (word_counter_q == `DSRS_WORD_ONE);
         end
         if (wr_acc_w && idle_w && (paddr == `DSRS_OFS_BUSADDR)) begin
            dma_addr_q <= pwdata[15:0];
         end else if (word_step_w) begin
            dma_addr_q <= dma_addr_q + `DSRS_BAR_STEP;
         end
      end
   end

   // Operation incomplete timeout, restarted on start and per good sector outside raw read
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tmo_cnt_q <= `DSRS_TMO_ZERO;
      end else if (ce) begin
         // restart on command and on a good sector outside raw read
         if (start_w || dar_inc_w || idle_w) begin
            tmo_cnt_q <= `DSRS_TMO_ZERO;
         end else if (!tmo_hit_w) begin
            tmo_cnt_q <= tmo_cnt_q + `DSRS_TMO_ONE;
         end
      end
   end

   // DMA enable, held off by overflow and by any error
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dma_en_q <= 1'b0;
      end else if (ce) begin
         dma_en_q <= dma_on_q && !wc_ovf_q && !err_any_w;
      end
   end

   // Command sequencer
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q                    <= ST_IDLE;
         bit_cnt_q               <= `DSRS_CNT_ZERO;
         data_sr_q               <= `DSRS_RST_WORD;
         push_left_q             <= `DSRS_RST_WORD;
         controller_ready_flag_q <= 1'b1;
         dma_on_q                <= 1'b0;
         err_hcrc_q              <= 1'b0;
         err_dcrc_q              <= 1'b0;
         err_late_q              <= 1'b0;
         err_tmo_q               <= 1'b0;
         fifo_wr_q               <= 1'b0;
         fifo_wdata_q            <= `DSRS_RST_WORD;
         irq_q                   <= 1'b0;
      end else if (ce) begin
         fifo_wr_q <= 1'b0;
         if (tmo_hit_w) begin
            err_tmo_q <= 1'b1;
            st_q      <= ST_DONE;
         end else begin
            case (st_q)
               ST_IDLE: begin
                  if (start_w) begin
                     controller_ready_flag_q <= 1'b0;
                     irq_q       <= 1'b0;
                     err_hcrc_q  <= 1'b0;
                     err_dcrc_q  <= 1'b0;
                     err_late_q  <= 1'b0;
                     err_tmo_q   <= 1'b0;
                     push_left_q <= word_counter_q;
                     case (pwdata[`DSRS_F_FN_HI:`DSRS_F_FN_LO])
                        `DSRS_FN_READ: st_q <= ST_DRDY;
                        `DSRS_FN_RAW:  st_q <= ST_DRDY;
                        default:       st_q <= ST_DONE;
                     endcase
                  end
               end
               ST_DRDY: begin
                  if (drive_ready) begin
                     dma_on_q <= 1'b1;
                     st_q     <= ST_SECT;
                  end
               end
               ST_SECT: begin
                  bit_cnt_q <= `DSRS_CNT_ZERO;
                  // act on the next sector pulse
                  if (sector_pulse) begin
                     if (!raw_w) begin
                        st_q <= ST_HDR;
                     end else if (fifo_half_empty) begin
                        st_q <= ST_DATA;
                     end else begin
                        err_late_q <= 1'b1;
                        st_q       <= ST_DONE;
                     end
                  end
               end
               ST_HDR: begin
                  if (rd_bit_stb) begin
                     bit_cnt_q <= bit_cnt_q + `DSRS_CNT_ONE;
                     if (bit_cnt_q == `DSRS_HDR_LAST) begin
                        st_q <= ST_HCHK;
                     end
                  end
               end
               ST_HCHK: begin
                  bit_cnt_q <= `DSRS_CNT_ZERO;
                  // no match, search the next header
                  if (hdr_miss_w) begin
                     st_q <= ST_SECT;
                  end else if (crc_w != `DSRS_CRC_INIT) begin
                     // error only on a matching header
                     err_hcrc_q <= 1'b1;
                     st_q       <= ST_DONE;
                  end else if (!fifo_half_empty) begin
                     // no room, catch it next revolution
                     st_q <= ST_SECT;
                  end else begin
                     st_q <= ST_DATA;
                  end
               end
               ST_DATA: begin
                  // same path for the raw read
                  if (rd_bit_stb) begin
                     bit_cnt_q <= bit_cnt_q + `DSRS_CNT_ONE;
                     data_sr_q <= {data_sr_q[14:0], rd_bit};
                     if ((bit_cnt_q[3:0] == `DSRS_WORD_END) &&
                         (bit_cnt_q <= `DSRS_DATA_LAST)) begin
                        fifo_wr_q    <= 1'b1;
                        fifo_wdata_q <= {data_sr_q[14:0], rd_bit};
                        if (push_left_q != `DSRS_RST_WORD) begin
                           push_left_q <= push_left_q - `DSRS_WORD_ONE;
                        end
                     end
                     if (bit_cnt_q == `DSRS_SECT_LAST) begin
                        st_q <= ST_DCHK;
                     end
                  end
               end
               ST_DCHK: begin
                  // data check word at sector end
                  if (crc_w != `DSRS_CRC_INIT) begin
                     err_dcrc_q <= 1'b1;
                     st_q       <= ST_DONE;
                  end else if (push_left_q == `DSRS_RST_WORD) begin
                     st_q <= ST_DRAIN;
                  end else begin
                     // next sector on the next pulse
                     st_q <= ST_SECT;
                  end
               end
               ST_DRAIN: begin
                  if (wc_ovf_q) begin
                     st_q <= ST_DONE;
                  end
               end
               ST_DONE: begin
                  controller_ready_flag_q <= 1'b1;
                  dma_on_q <= 1'b0;
                  irq_q    <= interrupt_enable_bit_q;
                  st_q     <= ST_IDLE;
               end
               default: begin
                  st_q <= ST_IDLE;
               end
            endcase
         end
      end
   end

endmodule
`default_nettype wire

// ==== bench/dsrs_drive_model.sv ====
/*
 Drive model: sector pulses, serial headers and data sectors.
 Assumes one bench process calls its tasks.
*/
`timescale 1ns/1ps
`default_nettype none
module dsrs_drive_model (
   // Clock
   input  wire logic pclk,
   // Serial read side
   output var  logic sector_pulse,
   output var  logic rd_bit_stb,
   output var  logic rd_bit
);
   logic [15:0] crc_q = 16'h0000;
   initial begin
      sector_pulse = 1'b0;
      rd_bit_stb = 1'b0;
      rd_bit = 1'b0;
   end
   // One word MSB first, one strobe every other cycle
   task automatic word(input logic [15:0] w);
      for (int i = 15; i >= 0; i--) begin
         @(posedge pclk);
         rd_bit_stb <= 1'b1;
         rd_bit <= w[i];
         crc_q = {crc_q[14:0], 1'b0} ^
                 ((crc_q[15] ^ w[i]) ? 16'h8005 : 16'h0000);
         @(posedge pclk);
         rd_bit_stb <= 1'b0;
         rd_bit <= ~w[i]; // Line is not held between bits
      end
   endtask
   // Gap, then a one-cycle sector pulse
   task automatic pulse();
      repeat (8) @(posedge pclk);
      sector_pulse <= 1'b1;
      @(posedge pclk);
      sector_pulse <= 1'b0;
      crc_q = 16'h0000;
   endtask
   // Header: address word, spare word, check word
   task automatic hdr(input logic [15:0] a);
      word(a);
      word(16'h0000);
      word(crc_q);
   endtask
   // Gap, 128 data words, check word corrupted on request
   task automatic data(input logic bad);
      repeat (8) @(posedge pclk);
      crc_q = 16'h0000;
      for (int i = 0; i < 128; i++) word(16'h5a00 | i[15:0]);
      word(crc_q ^ {15'h0000, bad});
   endtask
endmodule
`default_nettype wire

// ==== bench/dsrs_read_seq_asserts.sv ====
/*
 Port checks of the read sequencer.
 Assumes binding into dsrs_read_seq from the bench top.
*/
`timescale 1ns/1ps
`default_nettype none
module dsrs_chk (
   // Clock and reset
   input wire logic       pclk,
   input wire logic       presetn,
   // APB
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pwrite,
   input wire logic       pready_q,
   input wire logic       pslverr_q,
   // Drive, FIFO, DMA and request
   input wire logic       drive_ready,
   input wire logic       rd_bit_stb,
   input wire logic [1:0] drv_sel_q,
   input wire logic       fifo_wr_q,
   input wire logic       dma_en_q,
   input wire logic       irq_q
);
   logic wacc_q;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Remembers a write access cycle
   always @(posedge pclk) wacc_q <= psel & penable & pwrite;
   a_setup_answer: assert property (
      (psel && !penable) |=> pready_q) else $error("setup unanswered");
   a_ready_single: assert property (
      pready_q |-> psel && penable ##1 !pready_q) else $error("bad ready");
   a_slverr_pair: assert property (
      pslverr_q |-> pready_q) else $error("error without ready");
   a_fifo_strobe: assert property (
      fifo_wr_q |-> $past(rd_bit_stb) ##1 !fifo_wr_q)
      else $error("stray fifo write");
   a_fifo_dma: assert property (
      fifo_wr_q |-> dma_en_q) else $error("fifo write without dma");
   a_dma_drive: assert property (
      $rose(dma_en_q) |-> $past(drive_ready, 2))
      else $error("dma before drive ready");
   a_irq_hold: assert property (
      irq_q && !(psel && penable && pwrite) |=> irq_q)
      else $error("request dropped");
   a_sel_write: assert property (
      !$stable(drv_sel_q) |-> wacc_q) else $error("select moved");
endmodule
`default_nettype wire

// ==== bench/dsrs_read_seq_tb_top.sv ====
/*
 Bench top: APB master, drive model, DMA stand-in and checks.
 Assumes the design files and their constants header are on the path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dsrs_consts.vh"
module dsrs_read_seq_tb_top;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, drive_ready = 1'b0, fifo_half_empty = 1'b1;
   logic        ce = 1'b1;
   logic        dma_word_done = 1'b0, pready_q, pslverr_q, err, irq_q;
   logic        sector_pulse, rd_bit_stb, rd_bit, fifo_wr_q, dma_en_q;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata_q, rd;
   logic [1:0]  drv_sel_q;
   logic [15:0] fifo_wdata_q, dma_addr_q, nwr = 16'h0, n0;
   int          bad_count = 0, compares = 0;
   dsrs_read_seq #(.TMO_CYCLES(25'h4e20)) dut (.pclk, .presetn,
      .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata_q,
      .pready_q, .pslverr_q, .drive_ready, .sector_pulse, .rd_bit_stb,
      .rd_bit, .drv_sel_q, .fifo_half_empty, .fifo_wr_q, .fifo_wdata_q,
      .dma_word_done, .dma_en_q, .dma_addr_q, .irq_q);
   dsrs_drive_model drv (.pclk, .sector_pulse, .rd_bit_stb, .rd_bit);
   // Clock at 50 MHz
   initial forever #10 pclk = ~pclk;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // One APB transfer; read data and error taken at the ready edge
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [15:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {16'h0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready_q !== 1'b1 && n < 20);
      rd = prdata_q;
      err = pslverr_q;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         bad_count++;
         end_sim();
      end
   endtask
   task automatic wait_irq(input int lim);
      int n;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (irq_q !== 1'b1 && n < lim);
      if (n >= lim) begin
         bad_count++;
         end_sim();
      end
   endtask
   // DMA stand-in takes each word a cycle later; words checked in order
   always @(posedge pclk) begin
      dma_word_done <= fifo_wr_q & dma_en_q;
      if (fifo_wr_q === 1'b1) begin
         chk(fifo_wdata_q, 16'h5a00 | nwr[6:0]);
         nwr <= nwr + 16'h0001;
      end
   end
   // Main sequence
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `DSRS_OFS_CTL, 16'h0);
      chk(rd, 32'h0080);
      apb(1'b0, 12'h010, 16'h0);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, `DSRS_OFS_WORDCNT, 16'h0080);
      apb(1'b1, `DSRS_OFS_BUSADDR, 16'h0100);
      apb(1'b1, `DSRS_OFS_DISKADDR, 16'h0123);
      apb(1'b1, `DSRS_OFS_CTL, 16'h014c);
      apb(1'b1, `DSRS_OFS_DISKADDR, 16'h0777); // Busy: write ignored
      apb(1'b0, `DSRS_OFS_CTL, 16'h0);
      chk(rd & 32'h80, 32'h0);
      chk({31'h0, dma_en_q}, 32'h0);
      // Clock enable low freezes the wait for drive ready
      ce <= 1'b0;
      drive_ready <= 1'b1;
      repeat (5) @(posedge pclk);
      chk({31'h0, dma_en_q}, 32'h0);
      ce <= 1'b1;
      repeat (5) @(posedge pclk);
      chk({31'h0, dma_en_q}, 32'h1);
      drv.pulse();
      drv.hdr(16'h0122);
      drv.pulse();
      drv.hdr(16'h0123);
      drv.data(1'b0);
      wait_irq(2000);
      chk(nwr, 16'h0080);
      chk(dma_addr_q, 16'h0200);
      apb(1'b0, `DSRS_OFS_CTL, 16'h0);
      chk(rd, 32'h01cd);
      apb(1'b0, `DSRS_OFS_DISKADDR, 16'h0);
      chk(rd, 32'h0124);
      apb(1'b0, `DSRS_OFS_WORDCNT, 16'h0);
      chk(rd, 32'h0);
      fifo_half_empty <= 1'b0;
      apb(1'b1, `DSRS_OFS_CTL, 16'h004e);
      drv.pulse();
      wait_irq(200);
      apb(1'b0, `DSRS_OFS_CTL, 16'h0);
      chk(rd, 32'h90cf);
      fifo_half_empty <= 1'b1;
      apb(1'b1, `DSRS_OFS_WORDCNT, 16'h0100);
      apb(1'b1, `DSRS_OFS_CTL, 16'h004e);
      n0 = nwr;
      drv.pulse();
      drv.data(1'b0);
      drv.pulse();
      drv.data(1'b0);
      wait_irq(2000);
      chk(nwr - n0, 16'h0100);
      apb(1'b0, `DSRS_OFS_CTL, 16'h0);
      chk(rd, 32'h00cf);
      apb(1'b1, `DSRS_OFS_WORDCNT, 16'h0080);
      apb(1'b1, `DSRS_OFS_CTL, 16'h004e);
      drv.pulse();
      drv.data(1'b1);
      wait_irq(2000);
      apb(1'b0, `DSRS_OFS_CTL, 16'h0);
      chk(rd, 32'h88cf);
      drive_ready <= 1'b0;
      apb(1'b1, `DSRS_OFS_WORDCNT, 16'h0080);
      apb(1'b1, `DSRS_OFS_CTL, 16'h004c);
      wait_irq(25000);
      apb(1'b0, `DSRS_OFS_CTL, 16'h0);
      chk(rd, 32'ha0cc);
      // Unserved function completes at once
      apb(1'b1, `DSRS_OFS_CTL, 16'h0040);
      wait_irq(20);
      apb(1'b0, `DSRS_OFS_CTL, 16'h0);
      chk(rd, 32'h00c0);
      end_sim();
   end
endmodule
bind dsrs_read_seq dsrs_chk u_chk (.pclk, .presetn, .psel, .penable,
   .pwrite, .pready_q, .pslverr_q, .drive_ready, .rd_bit_stb, .drv_sel_q,
   .fifo_wr_q, .dma_en_q, .irq_q);
`default_nettype wire
